// file: dv/scd_clock_select_chk.sv
// Port checker for the serial clock selector
`timescale 1ns/1ps
`include "scd_params.svh"
module scd_clock_select_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        tx_active,
	input wire logic        tx_bit,
	input wire logic        txd,
	input wire logic        tx_bit_taken,
	input wire logic        rxd,
	input wire logic        rx_bit,
	input wire logic        rx_bit_valid,
	input wire logic        sclk_out
);
	// ==================================================================
	// Shadow of the configuration word
	logic [31:0] cfg_q;
	wire         acc    = psel && penable && pready;
	wire         mapped = paddr == 12'h000 || paddr == 12'h004;
	wire         cfg_wr = acc && pwrite && paddr == 12'h000;
	wire         txi    = !cfg_q[28];
	wire  [1:0]  tx_m   = cfg_q[28] ? 2'b00 : !cfg_q[30] ? 2'b10 : cfg_q[20:19];
	wire  [1:0]  rx_m   = cfg_q[29] ? 2'b00 : !cfg_q[30] ? 2'b10 : cfg_q[17:16];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cfg_q <= 32'h0000_0000;
		else if (cfg_wr)
			cfg_q <= pwdata & `SCD_CFG_WMASK;
	end
	// ==================================================================
	// Assertions
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Settle time covers the two-cycle delay of the clock level (phase flop, then output flop)
	sequence idle_s;
		(!tx_active && !cfg_wr && txi) [*4];
	endsequence
	chk_tx_fall_edge: assert property (
		tx_bit_taken && txi && !cfg_q[23] |-> !sclk_out)
		else $error("transmit data moved off the falling edge");
	chk_tx_rise_edge: assert property (
		tx_bit_taken && txi && cfg_q[23] |-> sclk_out)
		else $error("transmit data moved off the rising edge");
	chk_txd_follows: assert property (
		tx_bit_taken |-> txd == $past(tx_bit))
		else $error("txd does not carry the taken bit");
	chk_take_pulse: assert property (
		tx_bit_taken |=> !tx_bit_taken)
		else $error("take pulse longer than one cycle");
	chk_idle_level: assert property (
		idle_s |=> sclk_out == cfg_q[21] && !tx_bit_taken)
		else $error("idle clock level wrong");
	chk_cfg_readback: assert property (
		acc && !pwrite && paddr == 12'h000 |-> prdata == cfg_q)
		else $error("configuration read back wrong");
	chk_status_mult: assert property (
		acc && !pwrite && paddr == 12'h004 |-> prdata[3:0] == {rx_m, tx_m})
		else $error("effective multiplier wrong");
	chk_bad_addr: assert property (
		acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	chk_good_addr: assert property (
		acc && mapped |-> !pslverr)
		else $error("mapped access refused");
	// Two synchroniser flops plus the sampling flop
	chk_rx_sample: assert property (
		rx_bit_valid |-> rx_bit == $past(rxd, 3))
		else $error("receive bit not the sampled line");
	chk_rx_pulse: assert property (
		rx_bit_valid |=> !rx_bit_valid)
		else $error("receive pulse longer than one cycle");
endmodule // scd_clock_select_chk

// file: dv/scd_clock_select_tb.sv
// Register and serial clock tests for the clock selector
`timescale 1ns/1ps
module scd_clock_select_tb;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd;
	logic        tx_active = 0, rx_active = 0, tx_bit = 0, ext_en = 0, err_q;
	wire  [31:0] prdata;
	wire         pready, pslverr, rxd, etx, erx, txd, taken, rxb, rxv, sclk;
	int          errors = 0, tests_run = 0, ntx = 0, nrx = 0;
	always #2 pclk = ~pclk;
	scd_clock_select dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_tx_clk(etx), .ext_rx_clk(erx), .rxd(rxd), .tx_active(tx_active),
		.rx_active(rx_active), .tx_bit(tx_bit), .txd(txd),
		.tx_bit_taken(taken), .rx_bit(rxb), .rx_bit_valid(rxv),
		.sclk_out(sclk));
	scd_link_model u_link (.pclk(pclk), .ext_en(ext_en), .rxd(rxd),
		.ext_tx_clk(etx), .ext_rx_clk(erx));
	always @(posedge pclk) begin
		if (taken === 1'b1) begin
			tx_bit <= ~tx_bit;
			ntx++;
		end
		if (rxv === 1'b1)
			nrx++;
	end
	task check(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		err_q = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task run(input logic [31:0] c);
		apb(1, 12'h000, c, rd);
		ntx = 0;
		nrx = 0;
		repeat (300) @(posedge pclk);
		check(32'(ntx != 0), 32'h1);
		check(32'(nrx != 0), 32'h1);
	endtask
	task test_done;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		errors++;
		test_done;
	end
	// ==================================================================
	// Tests
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		apb(0, 12'h000, 32'h0, rd);
		check(rd, 32'h0000_0000);
		apb(0, 12'h004, 32'h0, rd);
		check(rd & 32'hF, 32'hA);
		apb(1, 12'h000, 32'hFFFF_FFFF, rd);
		apb(0, 12'h000, 32'h0, rd);
		check(rd, 32'hF0FB_57FF);
		apb(0, 12'h004, 32'h0, rd);
		check(rd & 32'hF, 32'h0);
		for (int k = 0; k < 4; k++) begin
			apb(1, 12'h000, 32'h4000_0000 | k << 19 | (3 - k) << 16, rd);
			apb(0, 12'h004, 32'h0, rd);
			check(rd & 32'hF, 32'((3 - k) << 2 | k));
		end
		apb(1, 12'h000, 32'h0009_0000, rd);
		apb(0, 12'h004, 32'h0, rd);
		check(rd & 32'hF, 32'hA);
		apb(0, 12'h008, 32'h0, rd);
		check({rd[30:0], err_q}, 32'h1);
		tx_active <= 1;
		rx_active <= 1;
		run(32'hC028_0001);
		run(32'hC0E9_0001);
		run(32'h4029_5001);
		ext_en <= 1;
		run(32'h3000_0000);
		ext_en <= 0;
		tx_active <= 0;
		apb(1, 12'h000, 32'hC028_0001, rd);
		repeat (8) @(posedge pclk);
		check(32'(sclk), 32'h1);
		test_done;
	end
endmodule // scd_clock_select_tb
bind scd_clock_select scd_clock_select_chk u_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .tx_active(tx_active), .tx_bit(tx_bit), .txd(txd),
	.tx_bit_taken(tx_bit_taken), .rxd(rxd), .rx_bit(rx_bit),
	.rx_bit_valid(rx_bit_valid), .sclk_out(sclk_out));

// file: dv/scd_link_model.sv
// Far-side serial device: external clocks and receive data
`timescale 1ns/1ps
module scd_link_model (
	input  wire logic pclk,
	input  wire logic ext_en,
	output logic      rxd,
	output logic      ext_tx_clk,
	output logic      ext_rx_clk
);
	logic [5:0] cnt = 6'h00;
	logic [2:0] div = 3'h0;
	initial begin
		rxd = 1'b1;
		ext_tx_clk = 1'b0;
	end
	assign ext_rx_clk = ext_tx_clk;
	always @(posedge pclk) begin
		cnt <= (cnt == 6'h24) ? 6'h00 : cnt + 6'h01;
		div <= div + 3'h1;
		// Odd spacing keeps edges off the divider phase
		if (cnt == 6'h24)
			rxd <= ~rxd;
		// Clock stands still outside traffic
		if (!ext_en)
			ext_tx_clk <= 1'b0;
		else if (div == 3'h7)
			ext_tx_clk <= ~ext_tx_clk;
	end
endmodule // scd_link_model

// file: rtl/scd_clock_select.sv
// Serial clock polarity, divide rate and source selector with APB access
//
// Functional notes
// - Invert clear: transmit data changes on falling edge
// - Invert set: transmit data changes on rising edge
// - Invert clear: receive data sampled on rising edge
// - Invert set: receive data sampled on falling edge
// - Idle level bit sets serial clock starting level with internal source
// - Transmit divide field selects transmit oversampling
// - Receive divide field selects receive oversampling
// - Divide field all zero gives 1x operation in legacy timing mode
// - Transmit select: divider or recovered clock
// - Transmit select applies only with internal source
// - Recovery from data edges, divider by division
// - Receive select: divider or recovered clock
// - Timing mode zero forces 16x operation with internal source
// - External clock source forces 1x operation
`timescale 1ns/1ps
`include "scd_params.svh"

module scd_clock_select (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ext_tx_clk,
	input  wire logic        ext_rx_clk,
	input  wire logic        rxd,
	input  wire logic        tx_active,
	input  wire logic        rx_active,
	input  wire logic        tx_bit,
	output logic             txd,
	output logic             tx_bit_taken,
	output logic             rx_bit,
	output logic             rx_bit_valid,
	output logic             sclk_out
);

	// ======================================================================
	// APB slave
	logic [31:0]      cfg_q;
	logic [31:0]      prdata_q;
	scd_pkg::scd_cfg_s cfg;
	logic [31:0]      stat_word;
	wire              hit_cfg  = (paddr == `SCD_CFG_OFF);
	wire              hit_stat = (paddr == `SCD_STAT_OFF);
	wire              mapped   = hit_cfg | hit_stat;
	wire              setup    = psel & ~penable;
	wire              wr_cfg   = psel & penable & pwrite & hit_cfg;
	wire [31:0]       rd_word  = hit_cfg  ? cfg_q :
	                             hit_stat ? stat_word : 32'h0000_0000;
	wire [31:0]       cfg_wr   = pwdata & `SCD_CFG_WMASK;

	assign cfg     = scd_pkg::scd_cfg_s'(cfg_q);
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata  = prdata_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= `SCD_CFG_RESET;
		end else if (wr_cfg) begin
			cfg_q <= cfg_wr;
		end
	end

	// Read data latched in setup so it comes from a flop in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup & ~pwrite) begin
			prdata_q <= rd_word;
		end
	end

	// ======================================================================
	// Pin synchronisers: 0 rxd, 1 tx clock pin, 2 rx clock pin
	wire  [2:0] sync2_q;
	wire  [2:0] pins = {ext_rx_clk, ext_tx_clk, rxd};

	genvar s;
	generate
		for (s = 0; s < 3; s++) begin : g_sync
			// One process per bit keeps a single driver per flop
			logic meta_q;
			logic held_q;

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta_q <= 1'b0;
					held_q <= 1'b0;
				end else begin
					meta_q <= pins[s];
					held_q <= meta_q;
				end
			end

			assign sync2_q[s] = held_q;
		end
	endgenerate

	wire rxd_s = sync2_q[0];

	// ======================================================================
	// Bit-rate divider: one tick every 2*(N+1) cycles
	logic [10:0] brg_cnt_q;
	logic        brg_half_q;
	logic        brg_tick_q;
	wire         brg_wrap = (brg_cnt_q == cfg.divide_n);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brg_cnt_q  <= 11'h000;
			brg_half_q <= 1'b0;
			brg_tick_q <= 1'b0;
		end else if (!cfg.brg_enable) begin
			brg_cnt_q  <= 11'h000;
			brg_half_q <= 1'b0;
			brg_tick_q <= 1'b0;
		end else begin
			brg_cnt_q  <= brg_wrap ? 11'h000 : brg_cnt_q + 11'h001;
			brg_half_q <= brg_half_q ^ brg_wrap;
			brg_tick_q <= brg_wrap & brg_half_q;
		end
	end

	// ======================================================================
	// Data-recovery loop: same nominal period, realigned on each data edge
	logic [11:0] data_recovery_loop_cnt_q;
	logic        data_recovery_loop_tick_q;
	logic        rxd_prev_q;
	wire  [11:0] data_recovery_loop_last = {divide_n_x2(cfg.divide_n)};
	wire         rxd_edge  = rxd_s ^ rxd_prev_q;
	wire         data_recovery_loop_wrap = (data_recovery_loop_cnt_q == data_recovery_loop_last);

	function automatic logic [11:0] divide_n_x2(input logic [10:0] n);
		divide_n_x2 = {n, 1'b1};
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_recovery_loop_cnt_q  <= 12'h000;
			data_recovery_loop_tick_q <= 1'b0;
			rxd_prev_q  <= 1'b0;
		end else begin
			rxd_prev_q <= rxd_s;
			if (rxd_edge | data_recovery_loop_wrap) begin
				data_recovery_loop_cnt_q  <= 12'h000;
				data_recovery_loop_tick_q <= 1'b1;
			end else begin
				data_recovery_loop_cnt_q  <= data_recovery_loop_cnt_q + 12'h001;
				data_recovery_loop_tick_q <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Per-direction clock: index 0 transmit, 1 receive
	wire [1:0] src_ext = {cfg.rx_clock_source, cfg.tx_clock_source};
	wire [1:0] int_sel = {cfg.rx_internal_clock_select,
	                      cfg.tx_internal_clock_select};
	wire [1:0] active  = {rx_active, tx_active};
	wire [1:0] pin_clk = {sync2_q[2], sync2_q[1]};
	wire [3:0] dcr     = {cfg.rx_divide_rate, cfg.tx_divide_rate};

	scd_pkg::scd_mult_e mult [2];
	logic [1:0]         clk_lvl;
	wire  [1:0]         lvl_prev_q;
	logic [1:0]         rise;
	logic [1:0]         fall;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_dir
			logic [3:0] cnt_q;
			logic [3:0] cnt_d;
			logic       phase_q;
			logic       phase_d;
			logic [3:0] last;
			logic       prev_q;
			wire        tick = int_sel[g] ? data_recovery_loop_tick_q : brg_tick_q;

			assign mult[g] = src_ext[g] ? scd_pkg::SCD_X1 :
			                 !cfg.legacy_timing_mode ? scd_pkg::SCD_X16 :
			                 scd_pkg::scd_mult_e'(dcr[2*g +: 2]);

			always_comb begin
				case (mult[g])
					scd_pkg::SCD_X8:  last = `SCD_HALF_X8;
					scd_pkg::SCD_X16: last = `SCD_HALF_X16;
					scd_pkg::SCD_X32: last = `SCD_HALF_X32;
					default:          last = 4'h0;
				endcase
			end

			always_comb begin
				cnt_d   = cnt_q;
				phase_d = phase_q;
				if (!active[g]) begin
					cnt_d   = 4'h0;
					phase_d = cfg.idle_clock_level;
				end else if (mult[g] == scd_pkg::SCD_X1) begin
					cnt_d   = 4'h0;
					phase_d = cfg.idle_clock_level ^ tick;
				end else if (tick) begin
					if (cnt_q == last) begin
						cnt_d   = 4'h0;
						phase_d = ~phase_q;
					end else begin
						cnt_d = cnt_q + 4'h1;
					end
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt_q   <= 4'h0;
					phase_q <= 1'b0;
					prev_q  <= 1'b0;
				end else begin
					cnt_q   <= cnt_d;
					phase_q <= phase_d;
					prev_q  <= clk_lvl[g];
				end
			end

			assign lvl_prev_q[g] = prev_q;

			assign clk_lvl[g] = src_ext[g] ? pin_clk[g] : phase_q;
			assign rise[g]    = clk_lvl[g] & ~lvl_prev_q[g];
			assign fall[g]    = ~clk_lvl[g] & lvl_prev_q[g];
		end
	endgenerate

	// ======================================================================
	// Data edges
	// Source switches mid-frame can give one stray edge; change them idle
	wire tx_shift = cfg.tx_clock_invert ? rise[0] : fall[0];
	wire rx_take  = cfg.rx_clock_invert ? fall[1] : rise[1];

	logic txd_q;
	logic tx_taken_q;
	logic rx_bit_q;
	logic rx_valid_q;
	logic sclk_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txd_q      <= 1'b1;
			tx_taken_q <= 1'b0;
			rx_bit_q   <= 1'b0;
			rx_valid_q <= 1'b0;
			sclk_q     <= 1'b0;
		end else begin
			tx_taken_q <= tx_shift;
			rx_valid_q <= rx_take;
			sclk_q     <= clk_lvl[0];
			if (tx_shift) begin
				txd_q <= tx_bit;
			end
			if (rx_take) begin
				rx_bit_q <= rxd_s;
			end
		end
	end

	assign txd          = txd_q;
	assign tx_bit_taken = tx_taken_q;
	assign rx_bit       = rx_bit_q;
	assign rx_bit_valid = rx_valid_q;
	assign sclk_out     = sclk_q;

	// ======================================================================
	// Status word
	always_comb begin
		stat_word                              = 32'h0000_0000;
		stat_word[`SCD_ST_TXM_LSB +: 2]        = mult[0];
		stat_word[`SCD_ST_RXM_LSB +: 2]        = mult[1];
		stat_word[`SCD_ST_TXLVL]               = clk_lvl[0];
		stat_word[`SCD_ST_RXLVL]               = clk_lvl[1];
		stat_word[`SCD_ST_RXD]                 = rxd_s;
	end

endmodule // scd_clock_select

// file: rtl/scd_params.svh
// Offsets, field positions, reset values and counts for the clock selector
`ifndef SCD_PARAMS_SVH
`define SCD_PARAMS_SVH

// ==========================================================================
// Register offsets
`define SCD_CFG_OFF      12'h000
`define SCD_STAT_OFF     12'h004

// ==========================================================================
// Configuration register
`define SCD_CFG_RESET    32'h0000_0000
`define SCD_CFG_WMASK    32'hF0FB_57FF

// ==========================================================================
// Status register field positions
`define SCD_ST_TXM_LSB   0
`define SCD_ST_RXM_LSB   2
`define SCD_ST_TXLVL     4
`define SCD_ST_RXLVL     5
`define SCD_ST_RXD       6

// ==========================================================================
// Half-period counts, in oversample ticks
`define SCD_HALF_X8      4'h3
`define SCD_HALF_X16     4'h7
`define SCD_HALF_X32     4'hF

`endif

// file: rtl/scd_pkg.sv
// Types shared by the serial clock polarity, divide and source selector
package scd_pkg;

	typedef enum logic [1:0] {
		SCD_X1  = 2'b00,
		SCD_X8  = 2'b01,
		SCD_X16 = 2'b10,
		SCD_X32 = 2'b11
	} scd_mult_e;

	// Same bit order as the configuration word
	typedef struct packed {
		logic        brg_enable;
		logic        legacy_timing_mode;
		logic        rx_clock_source;
		logic        tx_clock_source;
		logic [3:0]  rsvd27_24;
		logic        tx_clock_invert;
		logic        rx_clock_invert;
		logic        idle_clock_level;
		logic [1:0]  tx_divide_rate;
		logic        rsvd18;
		logic [1:0]  rx_divide_rate;
		logic        rsvd15;
		logic        tx_internal_clock_select;
		logic        rsvd13;
		logic        rx_internal_clock_select;
		logic        rsvd11;
		logic [10:0] divide_n;
	} scd_cfg_s;

endpackage
